// ### include/srx_pkg.sv
// Purpose: Shared constants for the receive status and arbiter block
// Assumes: 32-bit Avalon-MM register words, byte addresses
// Notes: Offsets are word aligned; narrow registers sit in the low bits
package srx_pkg;

    // =====================================================================
    // Bus geometry
    localparam int SRX_AW = 5;
    localparam int SRX_DW = 32;

    // =====================================================================
    // Register byte offsets
    localparam logic [4:0] SRX_OFS_STAT_ONE = 5'h00;
    localparam logic [4:0] SRX_OFS_STAT_TWO = 5'h04;
    localparam logic [4:0] SRX_OFS_DATA = 5'h08;
    localparam logic [4:0] SRX_OFS_ARB_CTRL = 5'h0C;
    localparam logic [4:0] SRX_OFS_ARB_CNT = 5'h10;
    localparam logic [4:0] SRX_OFS_CTRL_THREE = 5'h14;
    localparam logic [4:0] SRX_OFS_IRQ_STAT = 5'h18;
    localparam logic [4:0] SRX_OFS_CONFIG = 5'h1C;

    // =====================================================================
    // Field positions
    // receive_status_one
    localparam int SRX_S1_PE = 0;
    localparam int SRX_S1_FE = 1;
    localparam int SRX_S1_NF = 2;
    localparam int SRX_S1_RFULL = 5;
    // receive_status_two
    localparam int SRX_S2_RPF = 0;
    localparam int SRX_S2_BKF = 1;
    // arbiter_control
    localparam int SRX_AC_MEASUREMENT_DONE_FLAG = 0;
    localparam int SRX_AC_ARBITRATION_LOST_FLAG = 1;
    localparam int SRX_AC_ACLK = 5;
    localparam int SRX_AC_AM_LO = 6;
    localparam int SRX_AC_AM_HI = 7;
    // Event layout shared by irq status and serial_control_three mask
    localparam int SRX_EV_NF = 0;
    localparam int SRX_EV_FE = 1;
    localparam int SRX_EV_PE = 2;
    localparam int SRX_EV_ARBITRATION_LOST_FLAG = 3;
    localparam int SRX_EV_MEASUREMENT_DONE_FLAG = 4;
    localparam int SRX_EV_W = 5;
    // configuration_two
    localparam int SRX_CF_BDSRC = 0;

    // =====================================================================
    // Arbiter modes and reset values
    localparam logic [1:0] SRX_AM_IDLE = 2'h0;
    localparam logic [1:0] SRX_AM_MEAS = 2'h1;
    localparam logic [1:0] SRX_AM_ARB = 2'h2;
    localparam logic [1:0] SRX_AM_RSVD = 2'h3;
    localparam logic [1:0] SRX_RST_AM = 2'h0;
    localparam logic [4:0] SRX_RST_MASK = 5'h00;
    localparam int SRX_ARB_CW = 9;
    localparam int SRX_DIV_QUARTER = 4;
    localparam int SRX_PRESC_DIV = 16;

endpackage

// ### include/srx_arb_if.sv
// Purpose: Link between the status block and its arbiter counter
// Assumes: Both ends on clk_i
// Notes: Pulses are one clock wide
`timescale 1ns/1ps
`default_nettype none
interface srx_arb_if;
    logic [1:0] mode;
    logic aclk;
    logic presc_tick;
    logic rxd;
    logic tx_bit;
    logic tx_strobe;
    logic lost_set;
    logic fin_set;
    logic [9:0] count;

    modport ctrl (
        output mode, aclk, presc_tick, rxd, tx_bit, tx_strobe,
        input lost_set, fin_set, count
    );
    modport arb (
        input mode, aclk, presc_tick, rxd, tx_bit, tx_strobe,
        output lost_set, fin_set, count
    );
endinterface
`default_nettype wire

// ### rtl/srx_arbiter.sv
// Purpose: Arbiter counter with idle, measurement and arbitration modes
// Assumes: rxd already synchronised, presc_tick a one-cycle pulse
// Notes: Reserved mode behaves as idle
`timescale 1ns/1ps
`default_nettype none
module srx_arbiter
    import srx_pkg::*;
#(
    parameter int CW = srx_pkg::SRX_ARB_CW
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control link
    srx_arb_if.arb arb
);
    import srx_pkg::*;

    typedef struct packed {
        logic [1:0] bdiv;
        logic [1:0] pdiv;
        logic [CW-1:0] cnt;
        logic ovf;
        logic run;
        logic done;
        logic rx_prev;
        logic lost_set;
        logic fin_set;
    } srx_arb_st_t;

    srx_arb_st_t q, d;
    logic tick;
    logic fall;
    logic edge_seen;

    // =====================================================================
    // Next state
    always_comb
    begin
        d = q;
        d.lost_set = 1'b0;
        d.fin_set = 1'b0;
        d.rx_prev = arb.rxd;
        d.bdiv = q.bdiv + 2'h1;
        if (arb.presc_tick)
        begin
            d.pdiv = q.pdiv + 2'h1;
        end
        // Quarter of prescaler clock or bus clock over four
        tick = arb.aclk ? (arb.presc_tick && q.pdiv == 2'h3) : (q.bdiv == 2'h3);
        fall = q.rx_prev && !arb.rxd;
        edge_seen = q.rx_prev ^ arb.rxd;
        unique case (arb.mode)
            SRX_AM_MEAS:
            begin
                if (!q.run && !q.done && fall)
                begin
                    d.run = 1'b1;
                    d.cnt = '0;
                    d.ovf = 1'b0;
                end
                else if (q.run && edge_seen)
                begin
                    d.run = 1'b0;
                    d.done = 1'b1;
                    d.fin_set = 1'b1;
                end
            end
            SRX_AM_ARB:
            begin
                d.run = 1'b1;
                // Transmitted one read back as zero loses the bus
                if (arb.tx_strobe && arb.tx_bit && !arb.rxd)
                begin
                    d.lost_set = 1'b1;
                end
            end
            SRX_AM_IDLE, SRX_AM_RSVD:
            begin
                d.run = 1'b0;
                d.done = 1'b0;
                d.cnt = '0;
                d.ovf = 1'b0;
            end
        endcase
        if (q.run && d.run && tick)
        begin
            // Nine bits plus sticky overflow
            {d.ovf, d.cnt} = {q.ovf, q.cnt} + {1'b0, {(CW-1){1'b0}}, 1'b1};
            if (q.ovf)
            begin
                d.ovf = 1'b1;
            end
        end
    end

    // =====================================================================
    // State register
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            q <= '0;
            // Idle line level, so no false edge right after reset
            q.rx_prev <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign arb.lost_set = q.lost_set;
    assign arb.fin_set = q.fin_set;
    assign arb.count = 10'({q.ovf, q.cnt});

endmodule
`default_nettype wire

// ### rtl/srx_rx_status.sv
// Purpose: Receive status flags, arbiter control and register slave
// Assumes: Receiver core events arrive as one-cycle pulses on clk_i
// Notes: Pins rxd_i and osc_clk_i pass two flip-flops before use
`timescale 1ns/1ps
`default_nettype none

module srx_rx_status
    import srx_pkg::*;
#(
    parameter int PRESC_DIV = srx_pkg::SRX_PRESC_DIV
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Avalon-MM slave
    input wire logic [srx_pkg::SRX_AW-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [3:0] byteenable_i,
    input wire logic [srx_pkg::SRX_DW-1:0] writedata_i,
    output logic [srx_pkg::SRX_DW-1:0] readdata_o,
    output logic waitrequest_o,
    // Pins
    input wire logic rxd_i,
    input wire logic osc_clk_i,
    // Receiver core events
    input wire logic noise_evt_i,
    input wire logic frame_err_evt_i,
    input wire logic parity_err_evt_i,
    input wire logic break_evt_i,
    input wire logic rx_full_evt_i,
    input wire logic start_rt1_zero_i,
    input wire logic false_start_i,
    input wire logic idle_char_i,
    input wire logic [7:0] rx_data_i,
    // Transmit readback for arbitration
    input wire logic tx_bit_i,
    input wire logic tx_strobe_i,
    // Outputs
    output logic ninth_bit_clear_o,
    output logic irq_o
);
    import srx_pkg::*;

    localparam int PW = (PRESC_DIV > 1) ? $clog2(PRESC_DIV) : 1;
    localparam logic [PW-1:0] PRESC_LAST = PW'(PRESC_DIV - 1);

    typedef struct packed {
        logic rx_meta;
        logic rx_sync;
        logic osc_meta;
        logic osc_sync;
        logic osc_prev;
        logic [PW-1:0] presc_cnt;
        logic presc_tick;
        logic nf;
        logic fe;
        logic pe;
        logic break_flag;
        logic reception_active_flag;
        logic rfull;
        logic brk_armed;
        logic snap_nf;
        logic snap_fe;
        logic snap_pe;
        logic snap_bkf;
        logic [1:0] am;
        logic aclk;
        logic arbitration_lost_flag;
        logic measurement_done_flag;
        logic baud_src;
        logic [SRX_EV_W-1:0] mask;
        logic [SRX_EV_W-1:0] istat;
        logic wait_r;
        logic [SRX_DW-1:0] rdata;
        logic ninth_clr;
        logic irq;
    } srx_top_st_t;

    srx_top_st_t q, d;
    srx_arb_if arb_link ();

    logic start;
    logic wr_lo;
    logic rd_s1;
    logic rd_s2;
    logic rd_data;
    logic rd_istat;
    logic wr_actl;
    logic src_tick;
    logic brk_take;
    logic [SRX_EV_W-1:0] ev;
    logic [SRX_DW-1:0] rmux;

    // =====================================================================
    // Arbiter counter
    srx_arbiter #(
        .CW(SRX_ARB_CW)
    ) u_arbiter (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .arb(arb_link.arb)
    );

    assign arb_link.mode = q.am;
    assign arb_link.aclk = q.aclk;
    assign arb_link.presc_tick = q.presc_tick;
    assign arb_link.rxd = q.rx_sync;
    assign arb_link.tx_bit = tx_bit_i;
    assign arb_link.tx_strobe = tx_strobe_i;

    // =====================================================================
    // Next state
    always_comb
    begin
        d = q;
        d.ninth_clr = 1'b0;
        d.presc_tick = 1'b0;

        // Pin synchronisers
        d.rx_meta = rxd_i;
        d.rx_sync = q.rx_meta;
        d.osc_meta = osc_clk_i;
        d.osc_sync = q.osc_meta;
        d.osc_prev = q.osc_sync;

        // Serial prescaler, source picked by baud source bit
        src_tick = q.baud_src ? (q.osc_sync && !q.osc_prev) : 1'b1;
        if (src_tick)
        begin
            if (q.presc_cnt == PRESC_LAST)
            begin
                d.presc_cnt = '0;
                d.presc_tick = 1'b1;
            end
            else
            begin
                d.presc_cnt = q.presc_cnt + PW'(1);
            end
        end

        // Bus decode; one access per request, answered next cycle
        start = (read_i || write_i) && q.wait_r;
        wr_lo = start && write_i && byteenable_i[0];
        rd_s1 = start && read_i && address_i == SRX_OFS_STAT_ONE;
        rd_s2 = start && read_i && address_i == SRX_OFS_STAT_TWO;
        rd_data = start && read_i && address_i == SRX_OFS_DATA;
        rd_istat = start && read_i && address_i == SRX_OFS_IRQ_STAT;
        wr_actl = start && write_i && address_i == SRX_OFS_ARB_CTRL;
        d.wait_r = !start;

        unique case (address_i)
            SRX_OFS_STAT_ONE:
            begin
                rmux = '0;
                rmux[SRX_S1_PE] = q.pe;
                rmux[SRX_S1_FE] = q.fe;
                rmux[SRX_S1_NF] = q.nf;
                rmux[SRX_S1_RFULL] = q.rfull;
            end
            SRX_OFS_STAT_TWO:
            begin
                rmux = '0;
                rmux[SRX_S2_RPF] = q.reception_active_flag;
                rmux[SRX_S2_BKF] = q.break_flag;
            end
            SRX_OFS_DATA:
            begin
                rmux = {24'h000000, rx_data_i};
            end
            SRX_OFS_ARB_CTRL:
            begin
                rmux = '0;
                rmux[SRX_AC_AM_HI] = q.am[1];
                rmux[SRX_AC_AM_LO] = q.am[0];
                rmux[SRX_AC_ACLK] = q.aclk;
                rmux[SRX_AC_ARBITRATION_LOST_FLAG] = q.arbitration_lost_flag;
                rmux[SRX_AC_MEASUREMENT_DONE_FLAG] = q.measurement_done_flag;
            end
            SRX_OFS_ARB_CNT:
            begin
                rmux = {22'h0, arb_link.count};
            end
            SRX_OFS_CTRL_THREE:
            begin
                rmux = {27'h0, q.mask};
            end
            SRX_OFS_IRQ_STAT:
            begin
                rmux = {27'h0, q.istat};
            end
            SRX_OFS_CONFIG:
            begin
                rmux = {31'h0, q.baud_src};
            end
            default:
            begin
                // Unmapped and unaligned addresses read zero
                rmux = '0;
            end
        endcase
        if (start)
        begin
            d.rdata = read_i ? rmux : '0;
        end

        // Two-step clears: remember which flags were seen set
        if (rd_s1)
        begin
            d.snap_nf = q.nf;
            d.snap_fe = q.fe;
            d.snap_pe = q.pe;
        end
        if (rd_s2)
        begin
            d.snap_bkf = q.break_flag;
        end
        if (rd_data)
        begin
            if (q.snap_nf)
            begin
                d.nf = 1'b0;
            end
            if (q.snap_fe)
            begin
                d.fe = 1'b0;
            end
            if (q.snap_pe)
            begin
                d.pe = 1'b0;
            end
            if (q.snap_bkf)
            begin
                d.break_flag = 1'b0;
            end
            d.snap_nf = 1'b0;
            d.snap_fe = 1'b0;
            d.snap_pe = 1'b0;
            d.snap_bkf = 1'b0;
            d.rfull = 1'b0;
        end

        // Control writes, low byte lane only; any arbiter control write clears the done flag
        if (wr_lo && address_i == SRX_OFS_ARB_CTRL)
        begin
            d.am = writedata_i[SRX_AC_AM_HI:SRX_AC_AM_LO];
            d.aclk = writedata_i[SRX_AC_ACLK];
            if (!writedata_i[SRX_AC_AM_HI])
            begin
                d.arbitration_lost_flag = 1'b0;
            end
        end
        if (wr_actl)
        begin
            d.measurement_done_flag = 1'b0;
        end
        if (wr_lo && address_i == SRX_OFS_CTRL_THREE)
        begin
            d.mask = writedata_i[SRX_EV_W-1:0];
        end
        if (wr_lo && address_i == SRX_OFS_CONFIG)
        begin
            d.baud_src = writedata_i[SRX_CF_BDSRC];
        end

        // Break re-arms only once the line is seen idle high
        if (q.rx_sync && !q.break_flag)
        begin
            d.brk_armed = 1'b1;
        end
        brk_take = break_evt_i && q.brk_armed;

        // Flag sets come last so a set beats a clear in the same cycle
        if (noise_evt_i)
        begin
            d.nf = 1'b1;
        end
        if (frame_err_evt_i || break_evt_i)
        begin
            d.fe = 1'b1;
        end
        if (parity_err_evt_i)
        begin
            d.pe = 1'b1;
        end
        if (rx_full_evt_i || break_evt_i)
        begin
            d.rfull = 1'b1;
        end
        if (brk_take)
        begin
            d.break_flag = 1'b1;
            d.brk_armed = 1'b0;
            d.ninth_clr = 1'b1;
        end
        if (false_start_i || idle_char_i)
        begin
            d.reception_active_flag = 1'b0;
        end
        if (start_rt1_zero_i)
        begin
            d.reception_active_flag = 1'b1;
        end
        if (arb_link.lost_set)
        begin
            d.arbitration_lost_flag = 1'b1;
        end
        if (arb_link.fin_set)
        begin
            d.measurement_done_flag = 1'b1;
        end

        // Sticky event bits; break raises the framing bit, reception active never interrupts
        ev = '0;
        ev[SRX_EV_NF] = noise_evt_i;
        ev[SRX_EV_FE] = frame_err_evt_i || break_evt_i;
        ev[SRX_EV_PE] = parity_err_evt_i;
        ev[SRX_EV_ARBITRATION_LOST_FLAG] = arb_link.lost_set;
        ev[SRX_EV_MEASUREMENT_DONE_FLAG] = arb_link.fin_set;
        if (rd_istat)
        begin
            d.istat = '0;
        end
        d.istat = d.istat | ev;
        // Mask bits double as the per-flag interrupt enables
        d.irq = |(d.istat & d.mask);
    end

    // =====================================================================
    // State register
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            q <= '0;
            q.rx_meta <= 1'b1;
            q.rx_sync <= 1'b1;
            q.am <= SRX_RST_AM;
            q.mask <= SRX_RST_MASK;
            q.wait_r <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // =====================================================================
    // Outputs, all straight from flip-flops
    assign readdata_o = q.rdata;
    assign waitrequest_o = q.wait_r;
    assign ninth_bit_clear_o = q.ninth_clr;
    assign irq_o = q.irq;

endmodule
`default_nettype wire

// ### sim/srx_rx_status_properties.sv
// Purpose: Port-level checks of the receive status block
// Assumes: One clock, synchronous active-low reset
// Notes: Mask and mode are shadowed from bus writes
`timescale 1ns/1ps
`default_nettype none
module srx_rx_status_chk
    import srx_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Bus
    input wire logic [srx_pkg::SRX_AW-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [srx_pkg::SRX_DW-1:0] writedata_i,
    input wire logic [srx_pkg::SRX_DW-1:0] readdata_o,
    input wire logic waitrequest_o,
    // Line, events and outputs
    input wire logic rxd_i,
    input wire logic noise_evt_i,
    input wire logic frame_err_evt_i,
    input wire logic parity_err_evt_i,
    input wire logic break_evt_i,
    input wire logic tx_bit_i,
    input wire logic tx_strobe_i,
    input wire logic ninth_bit_clear_o,
    input wire logic irq_o
);
    import srx_pkg::*;
    // ====
    // Shadow of mask and mode
    logic take;
    logic [SRX_EV_W-1:0] mask_q;
    logic [1:0] mode_q;
    assign take = (read_i || write_i) && waitrequest_o;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            mask_q <= '0;
            mode_q <= 2'h0;
        end
        else if (take && write_i)
        begin
            if (address_i == SRX_OFS_CTRL_THREE)
                mask_q <= writedata_i[SRX_EV_W-1:0];
            if (address_i == SRX_OFS_ARB_CTRL)
                mode_q <= writedata_i[7:6];
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // ====
    // Properties
    wait_one_a: assert property (!waitrequest_o |=> waitrequest_o)
        else $error("waitrequest low longer than one cycle");
    bus_answer_a: assert property (take |=> !waitrequest_o)
        else $error("access not answered next cycle");
    reset_quiet_a: assert property (
        disable iff (1'b0) !rst_n_i |=> waitrequest_o && !irq_o && !ninth_bit_clear_o)
        else $error("outputs not quiet in reset");
    err_irq_a: assert property (
        |({parity_err_evt_i, frame_err_evt_i, noise_evt_i} & mask_q[2:0]) |-> ##[1:2] irq_o)
        else $error("enabled receive error gave no interrupt");
    masked_quiet_a: assert property (
        mask_q == '0 && $past(mask_q) == '0 |-> !irq_o)
        else $error("interrupt with all sources masked");
    lost_irq_a: assert property (
        tx_strobe_i && tx_bit_i && mode_q == SRX_AM_ARB && mask_q[SRX_EV_ARBITRATION_LOST_FLAG] && !rxd_i
        && !$past(rxd_i) && !$past(rxd_i, 2) && !$past(rxd_i, 3) |-> ##[2:4] irq_o)
        else $error("lost arbitration gave no interrupt");
    ninth_cause_a: assert property (
        ninth_bit_clear_o |-> $past(break_evt_i) || $past(break_evt_i, 2))
        else $error("ninth bit clear without break");
    ninth_single_a: assert property (ninth_bit_clear_o |=> !ninth_bit_clear_o)
        else $error("ninth bit clear longer than one cycle");
    quiet_read_a: assert property (
        take && (write_i || address_i[1:0] != 2'h0) |=> readdata_o == '0)
        else $error("nonzero data for write or unmapped read");
    cover property ($rose(irq_o));
    cover property (ninth_bit_clear_o);
    cover property (take && write_i && address_i == SRX_OFS_ARB_CTRL);
endmodule
bind srx_rx_status srx_rx_status_chk u_chk (.clk_i, .rst_n_i, .address_i, .read_i, .write_i,
    .writedata_i, .readdata_o, .waitrequest_o, .rxd_i, .noise_evt_i, .frame_err_evt_i,
    .parity_err_evt_i, .break_evt_i, .tx_bit_i, .tx_strobe_i, .ninth_bit_clear_o, .irq_o);
`default_nettype wire

// ### sim/srx_rx_node.sv
// Purpose: Remote node driving the serial receive line
// Assumes: Line idles high through its pull-up
// Notes: Levels change only just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module srx_rx_node
(
    // Clock
    input wire logic clk_i,
    // Receive line
    output logic rxd_o
);
    initial rxd_o = 1'b1;
    task automatic hold(input logic lvl);
        @(posedge clk_i);
        rxd_o <= lvl;
    endtask
    // Low frame, then back to idle ones so breaks can re-arm
    task automatic pulse_low(input int n);
        hold(1'b0);
        repeat (n) @(posedge clk_i);
        rxd_o <= 1'b1;
        @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Purpose: Self-checking bench for the receive status block
// Assumes: Remote node model drives the receive line
// Notes: Prescaler shortened to 2 to keep measurements brief
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import srx_pkg::*;
    localparam int PDIV = 2;
    // ====
    // Signals
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic wreq;
    logic rxd;
    logic osc = 1'b0;
    logic [7:0] ev = 8'h00;
    logic [7:0] rx_data = 8'h00;
    logic tx_bit = 1'b0;
    logic tx_stb = 1'b0;
    logic ninth;
    logic irq;
    int err_count = 0;
    int checks = 0;
    int nin = 0;
    always #2 clk_i = ~clk_i;
    always #11 osc = ~osc;
    always @(posedge clk_i)
        if (ninth === 1'b1)
            nin <= nin + 1;
    srx_rx_node u_node (.clk_i(clk_i), .rxd_o(rxd));
    srx_rx_status #(.PRESC_DIV(PDIV)) u_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(adr), .read_i(rd), .write_i(wr),
        .byteenable_i(4'hF), .writedata_i(wdat), .readdata_o(rdat), .waitrequest_o(wreq),
        .rxd_i(rxd), .osc_clk_i(osc), .noise_evt_i(ev[0]), .frame_err_evt_i(ev[1]),
        .parity_err_evt_i(ev[2]), .break_evt_i(ev[3]), .rx_full_evt_i(ev[4]),
        .start_rt1_zero_i(ev[5]), .false_start_i(ev[6]), .idle_char_i(ev[7]),
        .rx_data_i(rx_data), .tx_bit_i(tx_bit), .tx_strobe_i(tx_stb),
        .ninth_bit_clear_o(ninth), .irq_o(irq));
    // ====
    // Tasks
    task automatic print_verdict();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t pin got %b exp %b", $time, got, exp);
        end
    endtask
    // Extra edge at the end so a following access never re-drives in one step
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        rd <= !w;
        wr <= w;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (wreq !== 1'b0 && n < 40);
        if (n >= 40)
        begin
            err_count++;
            print_verdict();
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rdx(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk_reg(q, e);
    endtask
    task automatic pulse(input logic [7:0] m);
        ev <= m;
        @(posedge clk_i);
        ev <= 8'h00;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic strobe(input logic b);
        tx_bit <= b;
        tx_stb <= 1'b1;
        @(posedge clk_i);
        tx_stb <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    function automatic logic [31:0] s1_exp(input logic [7:0] m);
        logic [31:0] e;
        e = 32'h0;
        e[SRX_S1_NF] = m[0];
        e[SRX_S1_FE] = m[1];
        e[SRX_S1_PE] = m[2];
        e[SRX_S1_RFULL] = m[4];
        return e;
    endfunction
    // ====
    // Sequence
    initial
    begin
        logic [7:0] m;
        logic [7:0] v;
        int len;
        int n;
        int dv;
        void'($urandom(32'hCF0F));
        rx_data <= 8'($urandom);
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        for (int a = 0; a < 32; a += 4)
            rdx(5'(a), (a == SRX_OFS_DATA) ? {24'h0, rx_data} : 32'h0);
        bus(1'b1, 5'h1E, 32'hFFFF_FFFF);
        rdx(5'h1D, 32'h0);
        rdx(SRX_OFS_CONFIG, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            v = {i[1:0], 1'($urandom), 5'h00};
            bus(1'b1, SRX_OFS_ARB_CTRL, {24'h0, v});
            rdx(SRX_OFS_ARB_CTRL, {24'h0, v});
        end
        bus(1'b1, SRX_OFS_ARB_CTRL, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            m = (i == 0) ? 8'h17 : 8'($urandom) & 8'h17;
            v = 8'($urandom) & 8'h07;
            rx_data <= 8'($urandom);
            bus(1'b1, SRX_OFS_CTRL_THREE, {24'h0, v});
            pulse(m);
            chk_pin(irq, |(m[2:0] & v[2:0]));
            rdx(SRX_OFS_IRQ_STAT, {29'h0, m[2:0]});
            chk_pin(irq, 1'b0);
            rdx(SRX_OFS_DATA, {24'h0, rx_data});
            rdx(SRX_OFS_STAT_ONE, s1_exp(m & 8'h07));
            rdx(SRX_OFS_DATA, {24'h0, rx_data});
            rdx(SRX_OFS_STAT_ONE, 32'h0);
        end
        // All but framing enabled: break itself must stay silent
        bus(1'b1, SRX_OFS_CTRL_THREE, 32'h1D);
        // Line stays low through the clear, so no re-arm yet
        u_node.hold(1'b0);
        repeat (4) @(posedge clk_i);
        pulse(8'h08);
        chk_pin(irq, 1'b0);
        rdx(SRX_OFS_STAT_TWO, 32'h02);
        rdx(SRX_OFS_STAT_ONE, 32'h22);
        chk_reg(nin, 1);
        rdx(SRX_OFS_DATA, {24'h0, rx_data});
        rdx(SRX_OFS_STAT_TWO, 32'h0);
        rdx(SRX_OFS_STAT_ONE, 32'h0);
        pulse(8'h08);
        rdx(SRX_OFS_STAT_TWO, 32'h0);
        rdx(SRX_OFS_STAT_ONE, 32'h22);
        rdx(SRX_OFS_DATA, {24'h0, rx_data});
        u_node.hold(1'b1);
        repeat (4) @(posedge clk_i);
        pulse(8'h08);
        rdx(SRX_OFS_STAT_TWO, 32'h02);
        chk_reg(nin, 2);
        rdx(SRX_OFS_STAT_ONE, 32'h22);
        rdx(SRX_OFS_DATA, {24'h0, rx_data});
        pulse(8'h20);
        rdx(SRX_OFS_STAT_TWO, 32'h01);
        pulse(8'h40);
        rdx(SRX_OFS_STAT_TWO, 32'h0);
        pulse(8'h20);
        pulse(8'h80);
        rdx(SRX_OFS_STAT_TWO, 32'h0);
        for (int k = 0; k < 3; k++)
        begin
            // Third pass: prescaler on the 22 ns oscillator pin, 4 ns clock
            len = (k == 2) ? 400 + ($urandom % 100) : 40 + ($urandom % 40);
            dv = (k == 2) ? 22 * PDIV : (k == 1) ? 4 * PDIV : 4;
            if (k == 2)
                bus(1'b1, SRX_OFS_CONFIG, 32'h1);
            bus(1'b1, SRX_OFS_ARB_CTRL, 32'h40 | (32'(k > 0) << SRX_AC_ACLK));
            u_node.pulse_low(len);
            n = 0;
            q = 32'h0;
            while (q[SRX_AC_MEASUREMENT_DONE_FLAG] !== 1'b1 && n < 30)
            begin
                bus(1'b0, SRX_OFS_ARB_CTRL, 32'h0);
                n++;
            end
            chk_pin(q[SRX_AC_MEASUREMENT_DONE_FLAG], 1'b1);
            chk_pin(irq, 1'b1);
            bus(1'b0, SRX_OFS_ARB_CNT, 32'h0);
            chk_pin(int'(q) <= len / dv + 1 && int'(q) + 1 >= len / dv, 1'b1);
            bus(1'b1, SRX_OFS_ARB_CTRL, 32'h0);
            rdx(SRX_OFS_ARB_CTRL, 32'h0);
        end
        bus(1'b0, SRX_OFS_IRQ_STAT, 32'h0);
        bus(1'b1, SRX_OFS_CTRL_THREE, 32'h08);
        bus(1'b1, SRX_OFS_ARB_CTRL, 32'h80);
        u_node.hold(1'b0);
        repeat (4) @(posedge clk_i);
        strobe(1'b0);
        rdx(SRX_OFS_ARB_CTRL, 32'h80);
        strobe(1'b1);
        rdx(SRX_OFS_ARB_CTRL, 32'h82);
        chk_pin(irq, 1'b1);
        bus(1'b1, SRX_OFS_ARB_CTRL, 32'h80);
        rdx(SRX_OFS_ARB_CTRL, 32'h82);
        bus(1'b1, SRX_OFS_ARB_CTRL, 32'h0);
        rdx(SRX_OFS_ARB_CTRL, 32'h0);
        rdx(SRX_OFS_IRQ_STAT, 32'h08);
        chk_pin(irq, 1'b0);
        u_node.hold(1'b1);
        v = 8'($urandom);
        bus(1'b1, SRX_OFS_CONFIG, {24'h0, v});
        rdx(SRX_OFS_CONFIG, {31'h0, v[SRX_CF_BDSRC]});
        print_verdict();
    end
endmodule
`default_nettype wire
